/* pph_pkg.sv */
package pph_pkg;
   // status word bit positions
   localparam int unsigned SW_TORQUE_LIMIT = 15;
   localparam int unsigned SW_FOLLOW_ERR   = 13;
   localparam int unsigned SW_SETPT_ACK    = 12;
   localparam int unsigned SW_INT_LIMIT    = 11;
   localparam int unsigned SW_TARGET_REACH = 10;
   localparam int unsigned SW_WARNING      = 7;
   // control word bit positions
   localparam int unsigned CW_NEW_SETPT    = 4;
   localparam int unsigned CW_CHANGE_NOW   = 5;
   localparam int unsigned CW_ABS_REL      = 6;
   localparam int unsigned CW_HALT         = 8;
   localparam int unsigned CW_WRAP         = 14;
   localparam logic [7:0]  ALM_DEVIATION   = 8'h10;
   localparam logic [7:0]  ALM_OVERLOAD    = 8'h30;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam int unsigned POS_W           = 32;

   typedef enum logic [1:0] {PPH_MOVE_ABS, PPH_MOVE_REL, PPH_MOVE_WRAP} pph_move_t;

   typedef struct packed {
      logic [POS_W-1:0] target;
      pph_move_t        move;
   } pph_cmd_t;

   typedef enum {PPH_IDLE, PPH_MOVING, PPH_HALTING} pph_state_t;

   typedef struct packed {
      pph_state_t   fsm;
      logic         sp_prev;
      logic         ack;
      logic         follow_err;
      logic         pend_valid;
      pph_cmd_t     pend;
      pph_cmd_t     cmd;
      logic         start;
      logic [15:0]  status;
   } pph_state_all_t;
endpackage : pph_pkg

/* pph_profile_position.sv */
// Functional notes
// - bit 15 follows torque-limit reached
// - bit 13 set on deviation over window
// - bit 13 cleared by alarm 10h/30h reset
// - accepted start sets acknowledge bit 12
// - control bit 4 low clears bit 12
// - bit 11 while any internal limit active
// - bit 10 low while moving or decelerating
// - bit 7 follows information, self clearing
// - master loads target; bit 4 starts move
// - change-now bit replaces running move
// - otherwise new command queued until done
// - wrap bit selects the wrap move kind, ignores bit 6
// - halt bit 8 stops motion
// - refuse start on halt/stop/disabled/unexcited; a queued move still starts on move_done under stop/disabled/unexcited
`timescale 1ns/1ps
`default_nettype none
module pph_profile_position
   import pph_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              comm_cycle,
   // master process data, sampled on comm_cycle
   input  wire logic [15:0]       control_word,
   input  wire logic [POS_W-1:0]  target_position,
   // drive conditions, all levels on clk
   input  wire logic              torque_limit_reached,
   input  wire logic              deviation_over_window,
   input  wire logic              alarm_reset,
   input  wire logic [7:0]        alarm_code,
   // internal limit sources, then the information flag for bit 7
   input  wire logic              forward_limit_sensor,
   input  wire logic              reverse_limit_sensor,
   input  wire logic              forward_motion_block_input,
   input  wire logic              reverse_motion_block_input,
   input  wire logic              software_limit,
   input  wire logic              mechanism_limit,
   input  wire logic              info_present,
   // start gating and motion feedback
   input  wire logic              stop_input,
   input  wire logic              operation_enabled,
   input  wire logic              motor_excited,
   input  wire logic              move_done,
   input  wire logic              motor_stopped,
   output logic [15:0]            drive_status_word,
   output logic                   move_start,
   output logic                   move_halt,
   output pph_cmd_t               move_cmd
);
   logic [1:0]     rst_sync_q;
   logic           rst_n;

   // present and next block state
   pph_state_all_t s_q;
   pph_state_all_t s_d;

   // reset arrives asynchronously but leaves in step with clk, so no flop
   // of the state struct sees a release close to its edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // decodes the move kind at the moment of capture; wrap outranks the
   // abs/rel bit, so a wrap command never turns relative
   function automatic pph_cmd_t capture(input logic [15:0] cw, input logic [POS_W-1:0] tp);
      pph_cmd_t c;
      // target taken as is; its relative or wrap meaning is resolved downstream
      c.target = tp;
      if (cw[CW_WRAP]) begin
         c.move = PPH_MOVE_WRAP;
      end else if (cw[CW_ABS_REL]) begin
         c.move = PPH_MOVE_REL;
      end else begin
         c.move = PPH_MOVE_ABS;
      end
      return c;
   endfunction : capture

   // helpers, all given a value at the top of the process
   logic halt;
   logic rise;
   logic can_start;
   logic int_limit;
   logic fe_clear;
   logic reached;

   always_comb begin
      s_d       = s_q;
      // start is a pulse: it falls back unless a branch below raises it
      s_d.start = 1'b0;

      halt      = control_word[CW_HALT];
      // edge judged between communication cycles, not between clocks
      rise      = control_word[CW_NEW_SETPT] & ~s_q.sp_prev;
      // start gating: master supplies target before bit 4
      can_start = ~halt
                & ~stop_input
                & operation_enabled
                & motor_excited;

      // any single source is enough; the flag drops only when all are quiet
      int_limit = forward_limit_sensor
                | reverse_limit_sensor
                | forward_motion_block_input
                | reverse_motion_block_input
                | software_limit
                | mechanism_limit;
      fe_clear  = alarm_reset
                & ((alarm_code == ALM_DEVIATION)
                |  (alarm_code == ALM_OVERLOAD));
      reached   = 1'b0;

      // only the start pulse changes (falls) between communication cycles: the master reads process
      // data once per cycle, so anything in between would go unseen
      if (comm_cycle) begin
         // remembered every cycle, accepted or not, so the edge is consumed
         s_d.sp_prev = control_word[CW_NEW_SETPT];
         if (!control_word[CW_NEW_SETPT]) begin
            s_d.ack = 1'b0;
         end

         // deviation set wins over a same-cycle alarm reset
         if (deviation_over_window) begin
            s_d.follow_err = 1'b1;
         end else if (fe_clear) begin
            s_d.follow_err = 1'b0;
         end

         // a halt drops any queued command; after rest the master raises bit 4 anew
         // all three states are legal codes, so the case has no default
         unique case (s_q.fsm)
            PPH_IDLE: begin
               // a refused rise still updates sp_prev, so bit 4 must fall and rise again
               if (rise && can_start) begin
                  s_d.cmd   = capture(control_word, target_position);
                  s_d.start = 1'b1;
                  s_d.ack   = 1'b1;
                  s_d.fsm   = PPH_MOVING;
               end
            end

            PPH_MOVING: begin
               // halt outranks a rise in the same cycle
               if (halt) begin
                  s_d.fsm        = PPH_HALTING;
                  s_d.pend_valid = 1'b0;
               end else if (rise && can_start && control_word[CW_CHANGE_NOW]) begin
                  s_d.cmd   = capture(control_word, target_position);
                  s_d.start = 1'b1;
                  s_d.ack   = 1'b1;
               end else if (rise && can_start) begin
                  // one slot only: a newer queued command replaces an older one
                  s_d.pend       = capture(control_word, target_position);
                  s_d.pend_valid = 1'b1;
                  s_d.ack        = 1'b1;
               end else if (move_done && s_q.pend_valid) begin
                  // the queued command follows on without a stop in between
                  s_d.cmd        = s_q.pend;
                  s_d.pend_valid = 1'b0;
                  s_d.start      = 1'b1;
               end else if (move_done) begin
                  s_d.fsm = PPH_IDLE;
               end
            end

            PPH_HALTING: begin
               // rises are ignored here; the stop ends only when the motor rests
               if (motor_stopped) begin
                  s_d.fsm = PPH_IDLE;
               end
            end
         endcase

         // bit 10 low while moving or decelerating, high once done or stopped
         reached = (s_d.fsm == PPH_IDLE);

         // whole status word sampled only at cycle boundary; bits owned by
         // other blocks (14, 9, 8, 6 to 0) read as zero here
         s_d.status = STATUS_RESET;
         s_d.status[SW_TORQUE_LIMIT] = torque_limit_reached;
         // the held flag, not the raw input: it outlives the deviation itself
         s_d.status[SW_FOLLOW_ERR]   = s_d.follow_err;
         // ack mirrors the handshake state, never the one-cycle start pulse
         s_d.status[SW_SETPT_ACK]    = s_d.ack;
         s_d.status[SW_INT_LIMIT]    = int_limit;
         s_d.status[SW_TARGET_REACH] = reached;
         s_d.status[SW_WARNING]      = info_present;
      end
   end

   // the whole block state moves in this one register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{fsm:        PPH_IDLE,
                  sp_prev:    1'b0,
                  ack:        1'b0,
                  follow_err: 1'b0,
                  pend_valid: 1'b0,
                  pend:       '0,
                  cmd:        '0,
                  start:      1'b0,
                  status:     STATUS_RESET};
      end else begin
         s_q <= s_d;
      end
   end

   // status, start and command come straight from the state register; move_halt is decoded from fsm
   assign drive_status_word = s_q.status;
   assign move_start        = s_q.start;
   assign move_halt         = (s_q.fsm == PPH_HALTING);
   assign move_cmd          = s_q.cmd;
endmodule : pph_profile_position
`default_nettype wire

/* pph_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pph_master_model
   import pph_pkg::*;
(
   input  wire logic        clk,
   output logic [15:0]      control_word,
   output logic [POS_W-1:0] target_position
);
   initial {control_word, target_position} = '0;
   // target lands one clock ahead so the start never sees a stale value
   task automatic put(input logic [15:0] cw, input logic [POS_W-1:0] tgt);
      @(posedge clk) target_position <= tgt;
      @(posedge clk) control_word <= cw;
   endtask : put
endmodule : pph_master_model
`default_nettype wire

/* pph_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pph_monitor (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        comm_cycle,
   input wire logic [15:0] control_word,
   input wire logic        torque_limit_reached,
   input wire logic        deviation_over_window,
   input wire logic        info_present,
   input wire logic        motor_stopped,
   input wire logic        forward_limit_sensor,
   input wire logic        mechanism_limit,
   input wire logic [15:0] drive_status_word,
   input wire logic        move_start,
   input wire logic        move_halt
);
   logic [15:0] sw;
   assign sw = drive_status_word;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_torque_bit: assert property (comm_cycle |=> sw[15] == $past(torque_limit_reached))
      else $error("torque bit");
   chk_follow_set: assert property (comm_cycle && deviation_over_window |=> sw[13])
      else $error("follow bit");
   chk_limit_bit: assert property (comm_cycle && (forward_limit_sensor || mechanism_limit) |=> sw[11])
      else $error("limit bit");
   chk_warn_bit: assert property (comm_cycle |=> sw[7] == $past(info_present))
      else $error("warning bit");
   chk_ack_clear: assert property (comm_cycle && !control_word[4] |=> !sw[12])
      else $error("ack not cleared");
   chk_halt_refuse: assert property (comm_cycle && control_word[8] |=> !move_start)
      else $error("start while halted");
   chk_decel_low: assert property (comm_cycle && move_halt && !motor_stopped |=> !sw[10])
      else $error("target bit in decel");
   chk_stop_high: assert property (comm_cycle && move_halt && motor_stopped |=> sw[10])
      else $error("target bit after stop");
   chk_status_hold: assert property (!comm_cycle |=> $stable(sw) && !move_start)
      else $error("status off cycle");
   cover property (move_start);
   cover property (move_halt ##1 sw[10]);
   cover property (sw[12] ##1 !sw[12]);
endmodule : pph_monitor
bind pph_profile_position pph_monitor u_mon (
   .clk                   (clk),
   .reset_n               (reset_n),
   .comm_cycle            (comm_cycle),
   .control_word          (control_word),
   .torque_limit_reached  (torque_limit_reached),
   .deviation_over_window (deviation_over_window),
   .info_present          (info_present),
   .motor_stopped         (motor_stopped),
   .forward_limit_sensor  (forward_limit_sensor),
   .mechanism_limit       (mechanism_limit),
   .drive_status_word     (drive_status_word),
   .move_start            (move_start),
   .move_halt             (move_halt)
);
`default_nettype wire

/* profile_position_status_handshake_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module profile_position_status_handshake_bench import pph_pkg::*;;
   logic clk, reset_n, comm_cycle, torque_limit_reached, deviation_over_window, alarm_reset;
   logic forward_limit_sensor, reverse_limit_sensor, forward_motion_block_input, info_present;
   logic reverse_motion_block_input, software_limit, mechanism_limit, stop_input, move_halt;
   logic operation_enabled, motor_excited, move_done, motor_stopped, move_start;
   logic [7:0] alarm_code;
   logic [15:0] control_word, drive_status_word;
   logic [POS_W-1:0] target_position;
   pph_cmd_t move_cmd;
   int n_fail, comparisons;
   pph_profile_position DUT (
      .clk                        (clk),
      .reset_n                    (reset_n),
      .comm_cycle                 (comm_cycle),
      .control_word               (control_word),
      .target_position            (target_position),
      .torque_limit_reached       (torque_limit_reached),
      .deviation_over_window      (deviation_over_window),
      .alarm_reset                (alarm_reset),
      .alarm_code                 (alarm_code),
      .forward_limit_sensor       (forward_limit_sensor),
      .reverse_limit_sensor       (reverse_limit_sensor),
      .forward_motion_block_input (forward_motion_block_input),
      .reverse_motion_block_input (reverse_motion_block_input),
      .software_limit             (software_limit),
      .mechanism_limit            (mechanism_limit),
      .info_present               (info_present),
      .stop_input                 (stop_input),
      .operation_enabled          (operation_enabled),
      .motor_excited              (motor_excited),
      .move_done                  (move_done),
      .motor_stopped              (motor_stopped),
      .drive_status_word          (drive_status_word),
      .move_start                 (move_start),
      .move_halt                  (move_halt),
      .move_cmd                   (move_cmd)
   );
   pph_master_model M (
      .clk             (clk),
      .control_word    (control_word),
      .target_position (target_position)
   );
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task chk(input logic [39:0] g, e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) begin
         @(posedge clk) comm_cycle <= 1'h1;
         @(posedge clk) comm_cycle <= 1'h0;
      end
      #1;
   endtask : cyc
   task flags(input logic [8:0] v);
      {torque_limit_reached, info_present, deviation_over_window, forward_limit_sensor,
       reverse_limit_sensor, forward_motion_block_input, reverse_motion_block_input,
       software_limit, mechanism_limit} <= v;
   endtask : flags
   // lowers bit 4 first so every call presents a fresh rising edge
   task go(input logic [15:0] cw, input logic [31:0] tgt, input logic s);
      M.put(cw & 16'hffef, tgt);
      cyc(1);
      chk(drive_status_word[12], 1'h0);
      M.put(cw, tgt);
      cyc(1);
      chk(move_start, s);
   endtask : go
   task t_flags(input logic [7:0] code);
      alarm_reset <= 1'h0;
      flags(9'h1ff);
      cyc(1);
      chk(drive_status_word & 16'ha880, 16'ha880);
      flags(9'h0);
      {alarm_reset, alarm_code} <= {1'h1, code};
      cyc(1);
      chk(drive_status_word & 16'ha880, 16'h0);
   endtask : t_flags
   // each limit source alone raises bit 11; only codes 10h/30h clear bit 13
   task t_limits;
      {alarm_reset, alarm_code} <= {1'h1, 8'h20};
      for (int i = 0; i < 6; i++) begin
         flags(9'h001 << i);
         cyc(1);
         chk(drive_status_word[11], 1'h1);
      end
      flags(9'h040);
      cyc(1);
      flags(9'h0);
      cyc(1);
      chk(drive_status_word[13], 1'h1);
      {alarm_reset, alarm_code} <= {1'h1, ALM_DEVIATION};
      flags(9'h040);
      cyc(1);
      chk(drive_status_word[13], 1'h1);
      flags(9'h0);
      cyc(1);
      chk(drive_status_word[13], 1'h0);
   endtask : t_limits
   task t_moves;
      go(16'h0010, 32'h100, 1'h1);
      chk({move_cmd, drive_status_word[12:10]}, {32'h100, PPH_MOVE_ABS, 3'h4});
      go(16'h0070, 32'h200, 1'h1);
      chk(move_cmd, {32'h200, PPH_MOVE_REL});
      go(16'h0010, 32'h300, 1'h0);
      move_done <= 1'h1;
      cyc(1);
      chk({move_start, move_cmd}, {1'h1, 32'h300, PPH_MOVE_ABS});
      cyc(1);
      chk(drive_status_word[10], 1'h1);
      move_done <= 1'h0;
      go(16'h4050, 32'h400, 1'h1);
      chk(move_cmd, {32'h400, PPH_MOVE_WRAP});
   endtask : t_moves
   task t_halt;
      M.put(16'h0100, 32'h0);
      cyc(2);
      chk({move_halt, drive_status_word[10]}, 2'h2);
      motor_stopped <= 1'h1;
      cyc(1);
      chk(drive_status_word[10], 1'h1);
      go(16'h0110, 32'h500, 1'h0);
      M.put(16'h0, 32'h0);
      cyc(3);
      stop_input <= 1'h1;
      go(16'h0010, 32'h600, 1'h0);
      stop_input <= 1'h0;
      go(16'h0010, 32'h700, 1'h1);
   endtask : t_halt
   task finish_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   initial begin
      {reset_n, comm_cycle, alarm_reset, alarm_code, stop_input, operation_enabled,
       motor_excited, move_done, motor_stopped} = '0;
      flags(9'h0);
      repeat (8) @(posedge clk);
      {reset_n, operation_enabled, motor_excited} <= 3'h7;
      repeat (3) @(posedge clk);
      t_flags(ALM_DEVIATION);
      t_flags(ALM_OVERLOAD);
      t_limits;
      t_moves;
      t_halt;
      finish_test;
   end
   initial begin
      #100000;
      n_fail++;
      finish_test;
   end
endmodule : profile_position_status_handshake_bench
`default_nettype wire
